// [rtl/vcam_pkg.sv]
// package: constants and types for the virtual cam output axis
package vcam_pkg;
  localparam int unsigned VCAM_TBL_MAX     = 2048;
  localparam int unsigned VCAM_IDX_W       = 11;
  localparam int unsigned VCAM_CAMS        = 4;
  localparam int unsigned VCAM_CAMSEL_W    = 2;
  localparam logic [31:0] VCAM_STROKE_MAX  = 32'h7FFF_FFFF;
  localparam logic [15:0] VCAM_RATIO_FULL  = 16'h7FFF;
  localparam logic [15:0] VCAM_CAMS_PER_MC = 16'h0040;
  localparam logic [15:0] VCAM_MC_OFFSET   = 16'h0064;

  // register byte addresses
  localparam logic [11:0] VCAM_A_CTRL      = 12'h000;
  localparam logic [11:0] VCAM_A_STATUS    = 12'h004;
  localparam logic [11:0] VCAM_A_CAMNO     = 12'h008;
  localparam logic [11:0] VCAM_A_STROKE    = 12'h00C;
  localparam logic [11:0] VCAM_A_LOWER     = 12'h010;
  localparam logic [11:0] VCAM_A_GEARNUM   = 12'h014;
  localparam logic [11:0] VCAM_A_GEARDEN   = 12'h018;
  localparam logic [11:0] VCAM_A_NC        = 12'h01C;
  localparam logic [11:0] VCAM_A_CHGVAL    = 12'h020;
  localparam logic [11:0] VCAM_A_ERRCODE   = 12'h024;
  localparam logic [11:0] VCAM_A_FEED      = 12'h028;
  localparam logic [11:0] VCAM_A_REVPOS    = 12'h02C;
  localparam logic [11:0] VCAM_A_TBLSEL    = 12'h030;
  localparam logic [11:0] VCAM_A_TBLCFG    = 12'h034;
  localparam logic [11:0] VCAM_A_TBLDATA   = 12'h038;
  localparam logic [11:0] VCAM_A_BACKLASH  = 12'h03C;

  // ctrl bit positions
  localparam int unsigned VCAM_C_MODEREQ   = 0;
  localparam int unsigned VCAM_C_REFSET    = 1;
  localparam int unsigned VCAM_C_ERRCLR    = 2;
  localparam int unsigned VCAM_C_CHGPOS    = 3;
  localparam int unsigned VCAM_C_MACHINE   = 8;

  // tblcfg fields: [1:0] resolution code, [2] feed mode, [26:16] change point
  localparam int unsigned VCAM_T_RES       = 0;
  localparam int unsigned VCAM_T_FEED      = 2;
  localparam int unsigned VCAM_T_CHG       = 16;

  // reset values
  localparam logic [1:0]  VCAM_RES_RST     = 2'h0;
  localparam logic [31:0] VCAM_NC_RST      = 32'h0000_0100;
  localparam logic [31:0] VCAM_GEAR_RST    = 32'h0000_0001;

  // error codes
  localparam logic [15:0] VCAM_E_NONE      = 16'h0000;
  localparam logic [15:0] VCAM_E_STROKE    = 16'h0001;
  localparam logic [15:0] VCAM_E_SUM       = 16'h0002;
  localparam logic [15:0] VCAM_E_MODE      = 16'h0003;
  localparam logic [15:0] VCAM_E_CAMNO     = 16'h0004;

  typedef enum logic [1:0] {
    VCAM_REAL    = 2'b01,
    VCAM_VIRTUAL = 2'b10
  } vcam_mode_e;
endpackage

// [rtl/vcam_check.sv]
// combinational check of a cam number and stroke pair
`timescale 1ns/100ps
`default_nettype none
module vcam_check
  import vcam_pkg::*;
(
  // candidate values
  input  wire logic [15:0] camNo,
  input  wire logic [31:0] stroke,
  input  wire logic [31:0] lower,
  input  wire logic [3:0]  machine,
  input  wire logic [VCAM_CAMS-1:0] feedModes,
  // mode of cam in use
  input  wire logic        checkMode,
  input  wire logic        curFeed,
  // result
  output logic             ok,
  output logic [15:0]      code,
  output logic [VCAM_CAMSEL_W-1:0] sel,
  output logic             selFeed
);
  logic [15:0] base;
  logic [15:0] local1;
  logic [32:0] sum;
  always_comb
  begin
    base    = 16'(machine * VCAM_MC_OFFSET);
    local1  = camNo - base;
    sel     = local1[VCAM_CAMSEL_W-1:0] - VCAM_CAMSEL_W'(1);
    selFeed = feedModes[sel];
    sum     = {1'b0, lower} + {1'b0, stroke};
    code    = VCAM_E_NONE;
    // cam number offset by machine times 100, 1..64; only VCAM_CAMS tables are built
    if (camNo < base || local1 < 16'h0001 || local1 > VCAM_CAMS_PER_MC || local1 > 16'(VCAM_CAMS))
      code = VCAM_E_CAMNO;
    else if (stroke < 32'h0000_0001 || stroke > VCAM_STROKE_MAX)
      code = VCAM_E_STROKE;
    else if (!selFeed && (sum > {1'b0, VCAM_STROKE_MAX} || lower[31]))
      code = VCAM_E_SUM;
    else if (checkMode && selFeed != curFeed)
      code = VCAM_E_MODE;
    ok = (code == VCAM_E_NONE);
  end
endmodule
`default_nettype wire

// [rtl/vcam_table.sv]
// stroke-ratio tables, all cams in one array indexed by cam and entry, written from the bus
`timescale 1ns/100ps
`default_nettype none
module vcam_table
  import vcam_pkg::*;
(
  // clock
  input  wire logic        core_clk,
  // write port
  input  wire logic        wrEn,
  input  wire logic [VCAM_CAMSEL_W-1:0] wrCam,
  input  wire logic [VCAM_IDX_W-1:0]    wrIdx,
  input  wire logic [15:0] wrData,
  // read port
  input  wire logic [VCAM_CAMSEL_W-1:0] rdCam,
  input  wire logic [VCAM_IDX_W-1:0]    rdIdx,
  output logic [15:0]      rdData
);
  // no reset: table contents are loaded by software before use
  logic [15:0] mem [VCAM_CAMS*VCAM_TBL_MAX];
  always_ff @(posedge core_clk)
  begin
    if (wrEn)
      mem[{wrCam, wrIdx}] <= wrData;
  end
  assign rdData = mem[{rdCam, rdIdx}];
endmodule
`default_nettype wire

// [rtl/vcam_axis.sv]
// virtual cam output axis with apb register slave
`timescale 1ns/100ps
`default_nettype none
module vcam_axis
  import vcam_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // drive module travel, one sample per operation cycle
  input  wire logic        travelValid,
  input  wire logic signed [31:0] travelIn,
  // output to servo position loop
  output logic [31:0]      feedOut,
  output logic [31:0]      servoCmd,
  output logic             virtualActive,
  output logic             axis_error_flag
);
  typedef struct packed {
    vcam_mode_e  mode;
    logic        reqPrev;
    logic        refused;
    logic        errFlag;
    logic [15:0] errCode;
    logic [15:0] camSet;
    logic [31:0] strokeSet;
    logic [31:0] lower;
    logic [31:0] gearNum;
    logic [31:0] gearDen;
    logic [31:0] nc;
    logic [31:0] chgVal;
    logic [3:0]  machine;
    logic        refSet;
    logic [VCAM_CAMSEL_W-1:0] curCam;
    logic        curFeed;
    logic [31:0] curStroke;
    logic [31:0] revPos;
    logic [31:0] feed;
    logic [31:0] cycleBase;
    logic [VCAM_IDX_W-1:0] prevIdx;
    logic [VCAM_CAMSEL_W-1:0] tblSel;
    logic [VCAM_IDX_W-1:0]    tblIdx;
    logic [VCAM_CAMS-1:0][1:0] resCode;
    logic [VCAM_CAMS-1:0] feedMode;
    logic [VCAM_CAMS-1:0][VCAM_IDX_W-1:0] chgPt;
    logic [31:0] backlash;
    logic [31:0] rdata;
  } vcam_state_s;

  vcam_state_s st_ff;
  vcam_state_s nxt_st;

  logic        setupWr;
  logic        setupRd;
  logic        tblWr;
  logic [15:0] ratio;
  logic        chkOk;
  logic [15:0] chkCode;
  logic [VCAM_CAMSEL_W-1:0] chkSel;
  logic        chkFeed;
  logic [VCAM_IDX_W-1:0] idxNow;
  logic [63:0] scaled;
  logic [63:0] travelScaled;
  logic [47:0] prod;
  logic [31:0] strokePart;
  logic [31:0] idxMask;
  logic [31:0] newPos;
  logic        wrapped;
  logic        errEvent;

  assign setupWr = psel && !penable && pwrite;
  assign setupRd = psel && !penable && !pwrite;
  assign tblWr   = psel && penable && pwrite && paddr == VCAM_A_TBLDATA;

  vcam_check u_check (
    .camNo     (st_ff.camSet),
    .stroke    (st_ff.strokeSet),
    .lower     (st_ff.lower),
    .machine   (st_ff.machine),
    .feedModes (st_ff.feedMode),
    .checkMode (st_ff.mode == VCAM_VIRTUAL),
    .curFeed   (st_ff.curFeed),
    .ok        (chkOk),
    .code      (chkCode),
    .sel       (chkSel),
    .selFeed   (chkFeed)
  );

  vcam_table u_table (
    .core_clk (core_clk),
    .wrEn     (tblWr),
    .wrCam    (st_ff.tblSel),
    .wrIdx    (st_ff.tblIdx),
    .wrData   (pwdata[15:0]),
    .rdCam    (st_ff.curCam),
    .rdIdx    (idxNow),
    .rdData   (ratio)
  );

  always_comb
  begin
    nxt_st = st_ff;
    // resolution mask: 256 << code minus one
    idxMask = (32'h0000_0100 << st_ff.resCode[st_ff.curCam]) - 32'h0000_0001;
    scaled  = ({32'h0, st_ff.revPos} << (8 + st_ff.resCode[st_ff.curCam])) / {32'h0, st_ff.nc};
    idxNow  = VCAM_IDX_W'(scaled[31:0] & idxMask);
    // ratio of 32767 maps to the whole stroke
    prod       = 48'(st_ff.curStroke) * 48'(ratio[14:0]);
    strokePart = 32'(prod / 48'(VCAM_RATIO_FULL));
    // signed divide so reverse travel scales correctly
    travelScaled = 64'($signed(64'($signed(travelIn) * $signed({1'b0, st_ff.gearNum})))
                       / $signed({32'h0, st_ff.gearDen}));
    newPos  = st_ff.revPos;
    wrapped = 1'b0;
    errEvent = 1'b0;
    nxt_st.reqPrev = st_ff.reqPrev;

    // mode switch on rising request edge
    if (st_ff.mode == VCAM_REAL && nxt_st.reqPrev && !st_ff.refused)
    begin
      if (chkOk)
      begin
        nxt_st.mode      = VCAM_VIRTUAL;
        nxt_st.curCam    = chkSel;
        nxt_st.curFeed   = chkFeed;
        nxt_st.curStroke = st_ff.strokeSet;
        // reference set restarts at zero, otherwise keep position; feed base holds feed minus lower
        nxt_st.revPos    = st_ff.refSet ? 32'h0 : st_ff.revPos;
        nxt_st.cycleBase = st_ff.feed - st_ff.lower;
        nxt_st.prevIdx   = '0;
      end
      else
      begin
        nxt_st.refused = 1'b1;
        errEvent       = 1'b1;
        nxt_st.errFlag = 1'b1;
        nxt_st.errCode = chkCode;
      end
    end
    if (!nxt_st.reqPrev)
    begin
      nxt_st.refused = 1'b0;
      // leaving virtual mode keeps the last feed value
      nxt_st.mode    = VCAM_REAL;
    end

    if (st_ff.mode == VCAM_VIRTUAL)
    begin
      if (travelValid)
      begin
        newPos = st_ff.revPos + travelScaled[31:0];
        if ($signed(newPos) >= $signed(st_ff.nc))
        begin
          newPos  = newPos - st_ff.nc;
          wrapped = 1'b1;
        end
        else if ($signed(newPos) < 0)
          newPos = newPos + st_ff.nc;
        nxt_st.revPos = newPos;
      end
      // feed output, no stroke or speed limit checks applied
      nxt_st.feed = st_ff.lower + strokePart + (st_ff.curFeed ? st_ff.cycleBase : 32'h0);
      if (wrapped && st_ff.curFeed)
        nxt_st.cycleBase = st_ff.cycleBase + st_ff.curStroke;
      nxt_st.prevIdx = idxNow;
      // crossing the change point index
      if (idxNow != st_ff.prevIdx && idxNow == st_ff.chgPt[st_ff.curCam])
      begin
        if (chkOk)
        begin
          nxt_st.curCam    = chkSel;
          nxt_st.curStroke = st_ff.strokeSet;
        end
        else
        begin
          nxt_st.errFlag = 1'b1;
          errEvent       = 1'b1;
          nxt_st.errCode = chkCode;
        end
      end
    end

    // register writes take effect in setup, table data writes in access, so the slave answers with no wait
    nxt_st.rdata = st_ff.rdata;
    if (setupRd)
    begin
      case (paddr)
        VCAM_A_CTRL:     nxt_st.rdata = {20'h0, st_ff.machine, 6'h0, st_ff.refSet, st_ff.reqPrev};
        VCAM_A_STATUS:   nxt_st.rdata = {29'h0, st_ff.refused, st_ff.errFlag, st_ff.mode == VCAM_VIRTUAL};
        VCAM_A_CAMNO:    nxt_st.rdata = {16'h0, st_ff.camSet};
        VCAM_A_STROKE:   nxt_st.rdata = st_ff.strokeSet;
        VCAM_A_LOWER:    nxt_st.rdata = st_ff.lower;
        VCAM_A_GEARNUM:  nxt_st.rdata = st_ff.gearNum;
        VCAM_A_GEARDEN:  nxt_st.rdata = st_ff.gearDen;
        VCAM_A_NC:       nxt_st.rdata = st_ff.nc;
        VCAM_A_CHGVAL:   nxt_st.rdata = st_ff.chgVal;
        VCAM_A_ERRCODE:  nxt_st.rdata = {16'h0, st_ff.errCode};
        VCAM_A_FEED:     nxt_st.rdata = st_ff.feed;
        VCAM_A_REVPOS:   nxt_st.rdata = st_ff.revPos;
        VCAM_A_TBLSEL:   nxt_st.rdata = {5'h0, st_ff.tblIdx, 14'h0, st_ff.tblSel};
        VCAM_A_TBLCFG:   nxt_st.rdata = {5'h0, st_ff.chgPt[st_ff.tblSel], 13'h0,
                                         st_ff.feedMode[st_ff.tblSel], st_ff.resCode[st_ff.tblSel]};
        VCAM_A_BACKLASH: nxt_st.rdata = st_ff.backlash;
        default:         nxt_st.rdata = 32'h0;
      endcase
    end
    if (setupWr)
    begin
      case (paddr)
        VCAM_A_CTRL:
        begin
          nxt_st.reqPrev = pwdata[VCAM_C_MODEREQ];
          nxt_st.refSet  = pwdata[VCAM_C_REFSET];
          nxt_st.machine = pwdata[VCAM_C_MACHINE +: 4];
          // clear loses to an error raised in the same cycle
          if (pwdata[VCAM_C_ERRCLR] && !errEvent)
          begin
            nxt_st.errFlag = 1'b0;
            nxt_st.errCode = VCAM_E_NONE;
          end
          if (pwdata[VCAM_C_CHGPOS] && st_ff.mode == VCAM_VIRTUAL)
            nxt_st.revPos = st_ff.chgVal;
        end
        VCAM_A_CAMNO:    nxt_st.camSet    = pwdata[15:0];
        VCAM_A_STROKE:   nxt_st.strokeSet = pwdata;
        VCAM_A_LOWER:    nxt_st.lower     = pwdata;
        VCAM_A_GEARNUM:  nxt_st.gearNum   = pwdata;
        VCAM_A_GEARDEN:  nxt_st.gearDen   = (pwdata == 32'h0) ? VCAM_GEAR_RST : pwdata;
        VCAM_A_NC:       nxt_st.nc        = (pwdata == 32'h0) ? VCAM_NC_RST : pwdata;
        VCAM_A_CHGVAL:   nxt_st.chgVal    = pwdata;
        VCAM_A_TBLSEL:
        begin
          nxt_st.tblSel = pwdata[VCAM_CAMSEL_W-1:0];
          nxt_st.tblIdx = pwdata[16 +: VCAM_IDX_W];
        end
        VCAM_A_TBLCFG:
        begin
          nxt_st.resCode[st_ff.tblSel]  = pwdata[VCAM_T_RES +: 2];
          nxt_st.feedMode[st_ff.tblSel] = pwdata[VCAM_T_FEED];
          // change point masked into 0..resolution-1
          nxt_st.chgPt[st_ff.tblSel]    = pwdata[VCAM_T_CHG +: VCAM_IDX_W] &
                                          VCAM_IDX_W'((32'h0000_0100 << pwdata[VCAM_T_RES +: 2]) - 32'h1);
        end
        VCAM_A_BACKLASH: nxt_st.backlash  = pwdata;
        default:         nxt_st.rdata     = st_ff.rdata;
      endcase
    end
    if (tblWr)
      nxt_st.tblIdx = st_ff.tblIdx + VCAM_IDX_W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_ff          <= '0;
      st_ff.mode     <= VCAM_REAL;
      st_ff.gearNum  <= VCAM_GEAR_RST;
      st_ff.gearDen  <= VCAM_GEAR_RST;
      st_ff.nc       <= VCAM_NC_RST;
      st_ff.errCode  <= VCAM_E_NONE;
      st_ff.resCode  <= {VCAM_CAMS{VCAM_RES_RST}};
    end
    else
      st_ff <= nxt_st;
  end

  assign pready        = 1'b1;
  assign pslverr       = 1'b0;
  assign prdata        = st_ff.rdata;
  assign feedOut       = st_ff.feed;
  // backlash added in both modes from fixed setting
  assign servoCmd      = st_ff.feed + st_ff.backlash;
  assign virtualActive = (st_ff.mode == VCAM_VIRTUAL);
  assign axis_error_flag = st_ff.errFlag;

  // assertions
  property p_refuse;
    @(posedge core_clk) disable iff (sys_rst)
    (st_ff.mode == VCAM_REAL && st_ff.reqPrev && !st_ff.refused && !chkOk) |=> !virtualActive && axis_error_flag;
  endproperty
  a_refuse: assert property (p_refuse) else $error("switch not refused");

  property p_errcode;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(st_ff.errFlag) |-> st_ff.errCode != VCAM_E_NONE;
  endproperty
  a_errcode: assert property (p_errcode) else $error("error without code");

  property p_clear;
    @(posedge core_clk) disable iff (sys_rst)
    (setupWr && paddr == VCAM_A_CTRL && pwdata[VCAM_C_ERRCLR] && !errEvent)
      |=> !axis_error_flag && st_ff.errCode == VCAM_E_NONE;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_backlash;
    @(posedge core_clk) disable iff (sys_rst)
    servoCmd == feedOut + st_ff.backlash;
  endproperty
  a_backlash: assert property (p_backlash) else $error("backlash lost");

  property p_keepcam;
    @(posedge core_clk) disable iff (sys_rst)
    (virtualActive && !chkOk && nxt_st.reqPrev) |=> $stable(st_ff.curStroke) && $stable(st_ff.curCam);
  endproperty
  a_keepcam: assert property (p_keepcam) else $error("bad values adopted");

  property p_entry;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(virtualActive) |-> st_ff.cycleBase == $past(st_ff.feed) - $past(st_ff.lower);
  endproperty
  a_entry: assert property (p_entry) else $error("feed jump on entry");

  sequence s_feedHold;
    $stable(feedOut) ##1 $stable(feedOut);
  endsequence

  property p_exit;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(virtualActive) |-> s_feedHold;
  endproperty
  a_exit: assert property (p_exit) else $error("feed jump on exit");

  property p_range;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(virtualActive) |-> st_ff.curStroke >= 32'h1 && st_ff.curStroke <= VCAM_STROKE_MAX;
  endproperty
  a_range: assert property (p_range) else $error("stroke out of range");
endmodule
`default_nettype wire

// [tb/vcam_drive_model.sv]
// drive module model: feeds travel samples to the cam axis
`timescale 1ns/100ps
`default_nettype none
module vcam_drive_model
  import vcam_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  // control from bench
  input  wire logic          run,
  // travel to axis
  output logic               travelValid,
  output logic signed [31:0] travelIn
);
  // one pulse per cycle makes a 256-pulse turn last 256 cycles, the fastest legal pace
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      travelValid <= 1'b0;
      travelIn    <= 32'sh0000_0000;
    end
    else
    begin
      travelValid <= run;
      // idle data is inverted each cycle, so after a run it equals the real sample 1 on every second idle cycle
      travelIn    <= run ? 32'sh0000_0001 : ~travelIn;
    end
  end
endmodule
`default_nettype wire

// [tb/virtual_cam_output_axis_bench.sv]
// self-checking bench for the virtual cam output axis
`timescale 1ns/100ps
`default_nettype none
module virtual_cam_output_axis_bench
  import vcam_pkg::*;
;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] x;} vcam_row_s;
  typedef struct packed {logic [31:0] cam; logic [31:0] st; logic [31:0] lo; logic [31:0] code;} vcam_err_s;
  logic               core_clk = 1'b0;
  logic               sys_rst  = 1'b1;
  logic               psel     = 1'b0;
  logic               penable  = 1'b0;
  logic               pwrite   = 1'b0;
  logic [11:0]        paddr    = 12'h000;
  logic [31:0]        pwdata   = 32'h0000_0000;
  logic               run      = 1'b0;
  logic               pready;
  logic [31:0]        prdata;
  logic               travelValid;
  logic signed [31:0] travelIn;
  logic [31:0]        feedOut;
  logic [31:0]        servoCmd;
  logic               virtualActive;
  logic               axis_error_flag;
  logic [31:0]        rd;
  int                 miscompares = 0;
  int                 nTests      = 0;
  vcam_row_s rows [13] = '{'{1'b0, VCAM_A_GEARNUM, 32'h0, 32'h1}, '{1'b0, VCAM_A_GEARDEN, 32'h0, 32'h1},
    '{1'b0, VCAM_A_NC, 32'h0, 32'h100}, '{1'b0, VCAM_A_STATUS, 32'h0, 32'h0}, '{1'b0, VCAM_A_ERRCODE, 32'h0, 32'h0},
    '{1'b0, VCAM_A_FEED, 32'h0, 32'h0}, '{1'b0, VCAM_A_REVPOS, 32'h0, 32'h0}, '{1'b1, VCAM_A_CAMNO, 32'h1, 32'h1},
    '{1'b1, VCAM_A_STROKE, 32'h3E8, 32'h3E8}, '{1'b1, VCAM_A_LOWER, 32'h64, 32'h64},
    '{1'b1, VCAM_A_CHGVAL, 32'h10, 32'h10}, '{1'b1, VCAM_A_BACKLASH, 32'h5, 32'h5},
    '{1'b1, 12'h100, 32'hFFFF, 32'h0}};
  vcam_err_s errs [5] = '{'{32'h1, 32'h0, 32'h0, 32'h1}, '{32'h1, 32'h8000_0000, 32'h0, 32'h1},
    '{32'h1, 32'h7FFF_FFFF, 32'h1, 32'h2}, '{32'h41, 32'hA, 32'h0, 32'h4}, '{32'h65, 32'hA, 32'h0, 32'h4}};

  always #50 core_clk = ~core_clk;

  vcam_axis u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(), .travelValid(travelValid),
    .travelIn(travelIn), .feedOut(feedOut), .servoCmd(servoCmd), .virtualActive(virtualActive),
    .axis_error_flag(axis_error_flag));
  vcam_drive_model u_drive (.core_clk(core_clk), .sys_rst(sys_rst), .run(run), .travelValid(travelValid),
    .travelIn(travelIn));

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t ns: seen %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic drive(input int n);
    run <= 1'b1;
    repeat (n) @(posedge core_clk);
    run <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].x);
    end
    apb(1'b1, VCAM_A_TBLSEL, 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, VCAM_A_TBLCFG, 32'(k));
      apb(1'b0, VCAM_A_TBLCFG, 32'h0);
      chk(rd & 32'h3, 32'(k));
    end
    // second cam runs in feed mode, so picking it later is a mode clash
    apb(1'b1, VCAM_A_TBLSEL, 32'h1);
    apb(1'b1, VCAM_A_TBLCFG, 32'h4);
    apb(1'b1, VCAM_A_TBLSEL, 32'h0);
    apb(1'b1, VCAM_A_TBLCFG, 32'h0);
    // flat full-stroke table: feed is independent of where the turn stands
    repeat (256) apb(1'b1, VCAM_A_TBLDATA, 32'h7FFF);
    foreach (errs[i])
    begin
      apb(1'b1, VCAM_A_CAMNO, errs[i].cam);
      apb(1'b1, VCAM_A_STROKE, errs[i].st);
      apb(1'b1, VCAM_A_LOWER, errs[i].lo);
      apb(1'b1, VCAM_A_CTRL, 32'h1);
      repeat (3) @(posedge core_clk);
      chk({31'h0, virtualActive}, 32'h0);
      chk({31'h0, axis_error_flag}, 32'h1);
      apb(1'b0, VCAM_A_ERRCODE, 32'h0);
      chk(rd, errs[i].code);
      apb(1'b1, VCAM_A_CTRL, 32'h4);
      repeat (2) @(posedge core_clk);
      apb(1'b0, VCAM_A_ERRCODE, 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, VCAM_A_CAMNO, 32'h1);
    apb(1'b1, VCAM_A_STROKE, 32'h3E8);
    apb(1'b1, VCAM_A_LOWER, 32'h64);
    apb(1'b1, VCAM_A_CTRL, 32'h3);
    apb(1'b1, VCAM_A_CTRL, 32'h1);
    repeat (3) @(posedge core_clk);
    chk({31'h0, virtualActive}, 32'h1);
    drive(40);
    apb(1'b0, VCAM_A_REVPOS, 32'h0);
    chk(rd, 32'h28);
    chk(feedOut, 32'h44C);
    chk(servoCmd, 32'h451);
    apb(1'b1, VCAM_A_CTRL, 32'h9);
    apb(1'b1, VCAM_A_CTRL, 32'h1);
    apb(1'b0, VCAM_A_REVPOS, 32'h0);
    chk(rd, 32'h10);
    apb(1'b1, VCAM_A_STROKE, 32'h7D0);
    repeat (4) @(posedge core_clk);
    chk(feedOut, 32'h44C);
    drive(300);
    chk(feedOut, 32'h834);
    apb(1'b1, VCAM_A_CAMNO, 32'h2);
    drive(300);
    chk({31'h0, axis_error_flag}, 32'h1);
    apb(1'b0, VCAM_A_ERRCODE, 32'h0);
    chk(rd, 32'h3);
    chk(feedOut, 32'h834);
    chk({31'h0, virtualActive}, 32'h1);
    apb(1'b1, VCAM_A_CTRL, 32'h5);
    repeat (2) @(posedge core_clk);
    chk({31'h0, axis_error_flag}, 32'h0);
    apb(1'b1, VCAM_A_CTRL, 32'h0);
    repeat (3) @(posedge core_clk);
    chk({31'h0, virtualActive}, 32'h0);
    chk(feedOut, 32'h834);
    chk(servoCmd, 32'h839);
    finish_test();
  end
endmodule
`default_nettype wire
